// ==== rtl/mmp_pkg.sv ====
// package for the memory-map position register block
package mmp_pkg;
  // register offsets (word offsets, compared against paddr[11:2])
  localparam logic [10:0] OFF_RAM_POS   = 11'h010;
  localparam logic [10:0] OFF_REG_POS   = 11'h011;
  localparam logic [10:0] OFF_EE_POS    = 11'h012;
  localparam logic [10:0] OFF_MISC      = 11'h013;
  localparam logic [10:0] OFF_TEST0     = 11'h014;
  localparam logic [10:0] OFF_TEST1     = 11'h017;
  localparam logic [10:0] OFF_MEMSIZE0  = 11'h01c;
  localparam logic [10:0] OFF_MEMSIZE1  = 11'h01d;
  localparam logic [10:0] OFF_PAGE      = 11'h030;
  localparam logic [10:0] OFF_PAGE_RSVD = 11'h031;
  // field positions and masks
  localparam int          BASE_LSB      = 3;
  localparam int          RAM_ALIGN_BIT = 0;
  localparam int          EE_ENABLE_BIT = 0;
  localparam int          SIZE_SW_BIT   = 7;
  localparam logic [7:0]  RAM_POS_MASK  = 8'hf9;
  localparam logic [7:0]  REG_POS_MASK  = 8'h78;
  localparam logic [7:0]  EE_POS_MASK   = 8'hf9;
  localparam logic [7:0]  MISC_MASK     = 8'h0f;
  localparam logic [7:0]  PAGE_MASK     = 8'h3f;
  // reset values
  localparam logic [7:0]  RAM_POS_RST   = 8'h00;
  localparam logic [7:0]  REG_POS_RST   = 8'h00;
  localparam logic [7:0]  MISC_RST      = 8'h0d;
  localparam logic [7:0]  MISC_TEST_RST = 8'h0c;
  localparam logic [7:0]  PAGE_RST      = 8'h00;
  // window sizes in address bits
  localparam int          REG_SMALL_BITS = 10;
  localparam int          REG_LARGE_BITS = 11;
  localparam int          RAM_BITS       = 11;
  localparam int          EE_BITS        = 11;
  // decoder result
  typedef enum logic [1:0] {SEL_NONE, SEL_REGS, SEL_RAM, SEL_EEPROM} mmp_sel_t;
endpackage

// ==== rtl/mmp_decode_if.sv ====
// interface carrying live map settings from the register bank to the decoder
`timescale 1ns/10ps
`default_nettype none
interface mmp_decode_if;
  logic [4:0] ramBase;
  logic       ramHighAlign;
  logic [3:0] regBase;
  logic       regLarge;
  logic [4:0] eeBase;
  logic       eeEnable;
  modport bank (output ramBase, ramHighAlign, regBase, regLarge, eeBase, eeEnable);
  modport dec  (input  ramBase, ramHighAlign, regBase, regLarge, eeBase, eeEnable);
endinterface
`default_nettype wire

// ==== rtl/mmp_decoder.sv ====
// priority address decoder for registers, ram and eeprom windows
`timescale 1ns/10ps
`default_nettype none
module mmp_decoder (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // live map settings
  mmp_decode_if.dec            cfg,
  // core address
  input  wire logic [15:0]     coreAddr,
  // registered selects
  output var  mmp_pkg::mmp_sel_t sel
);
  logic regHit;
  logic ramHit;
  logic eeHit;
  logic [4:0] ramTop;

  // window hits; ram high-align moves the ram window to the top 2k-aligned slot (5'h1f), ignoring ramBase
  always_comb begin
    ramTop = cfg.ramHighAlign ? 5'h1f : cfg.ramBase;
    regHit = cfg.regLarge ? (coreAddr[15:11] == {1'b0, cfg.regBase})
                          : (coreAddr[15:11] == {1'b0, cfg.regBase}) && !coreAddr[10];
    ramHit = (coreAddr[15:11] == (cfg.ramHighAlign ? ramTop : cfg.ramBase));
    eeHit  = cfg.eeEnable && (coreAddr[15:11] == cfg.eeBase);
  end

  // registers first, then ram, then eeprom so only one resource answers
  always_ff @(posedge clk) begin
    if (rst) begin
      sel <= mmp_pkg::SEL_NONE;
    end else if (regHit) begin
      sel <= mmp_pkg::SEL_REGS;
    end else if (ramHit) begin
      sel <= mmp_pkg::SEL_RAM;
    end else if (eeHit) begin
      sel <= mmp_pkg::SEL_EEPROM;
    end else begin
      sel <= mmp_pkg::SEL_NONE;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/mmp_position_regs.sv ====
// memory-map position register bank with apb slave and address decode
`timescale 1ns/10ps
`default_nettype none
module mmp_position_regs #(
  parameter logic [7:0] EE_POS_RESET    = 8'h00,
  parameter bit         EE_WRITE_ONCE   = 1'b0,
  parameter logic [7:0] TEST0_VALUE     = 8'h00,
  parameter logic [7:0] TEST1_VALUE     = 8'h00,
  parameter logic [7:0] MEMSIZE0_LOW    = 8'h00,
  parameter logic [7:0] MEMSIZE1_VALUE  = 8'h00
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // operating mode and integration switches
  input  wire logic        specialMode,
  input  wire logic        registerSpaceSizeSwitch,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // core side address decode
  input  wire logic [15:0] coreAddr,
  output logic             selRegs,
  output logic             selRam,
  output logic             selEeprom,
  // live settings for other core logic
  output logic [1:0]       extStretch,
  output logic             romHighOnly,
  output logic             romEnable,
  output logic [5:0]       pageIndex
);
  // ****************************************************************
  // register storage
  // ****************************************************************
  // stored images; unimplemented bits are masked to zero on every write
  logic [7:0] ramPosition;
  logic [7:0] registerSpacePosition;
  logic [7:0] eepromPosition;
  logic [7:0] miscSystemControl;
  logic [7:0] programPageIndex;

  // write-once locks, cleared only by reset
  logic       ramWritten;
  logic       regWritten;
  logic       eeWritten;
  logic       miscWritten;

  // captured size strap and the mode synchroniser
  logic       sizeSwitch;
  logic       sizeSwitchLoaded;
  logic       specialMode0;
  logic       specialModeSync;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // decoded view of the bus request in flight
  logic        access;
  logic        wrEn;
  logic [10:0] offset;
  logic        hitModule;
  logic        mapped;
  logic [7:0]  readByte;

  // apb offsets decode from paddr alone; the register base does not move this window
  always_comb begin
    offset    = {1'b0, paddr[11:2]};
    // a byte address off the word boundary is not a register
    hitModule = (paddr[1:0] == 2'b00);
    mapped    = 1'b0;
    readByte  = 8'h00;
    case (offset)
      mmp_pkg::OFF_RAM_POS: begin
        mapped   = 1'b1;
        readByte = ramPosition & mmp_pkg::RAM_POS_MASK;
      end
      mmp_pkg::OFF_REG_POS: begin
        mapped   = 1'b1;
        readByte = registerSpacePosition & mmp_pkg::REG_POS_MASK;
      end
      mmp_pkg::OFF_EE_POS: begin
        mapped   = 1'b1;
        readByte = eepromPosition & mmp_pkg::EE_POS_MASK;
      end
      mmp_pkg::OFF_MISC: begin
        mapped   = 1'b1;
        readByte = miscSystemControl & mmp_pkg::MISC_MASK;
      end
      mmp_pkg::OFF_TEST0: begin
        mapped   = 1'b1;
        readByte = TEST0_VALUE;
      end
      mmp_pkg::OFF_TEST1: begin
        mapped   = 1'b1;
        readByte = TEST1_VALUE;
      end
      mmp_pkg::OFF_MEMSIZE0: begin
        mapped   = 1'b1;
        readByte = {sizeSwitch, MEMSIZE0_LOW[6:0]};
      end
      mmp_pkg::OFF_MEMSIZE1: begin
        mapped   = 1'b1;
        readByte = MEMSIZE1_VALUE;
      end
      mmp_pkg::OFF_PAGE: begin
        mapped   = 1'b1;
        readByte = programPageIndex & mmp_pkg::PAGE_MASK;
      end
      mmp_pkg::OFF_PAGE_RSVD: begin
        mapped   = 1'b1;
        readByte = 8'h00;
      end
      default: begin
        mapped   = 1'b0;
        readByte = 8'h00;
      end
    endcase
    mapped = mapped && hitModule;
  end

  // single-wait-free access; only lane 0 carries a register byte
  assign access = psel && penable && pready;
  assign wrEn   = access && pwrite && pstrb[0] && mapped;

  // ****************************************************************
  // write strobes and write rights
  // ****************************************************************
  logic wrRamPos;
  logic wrRegPos;
  logic wrEePos;
  logic wrMisc;
  logic wrPage;
  logic ramMayWrite;
  logic regMayWrite;
  logic eeBaseMayWrite;
  logic miscMayWrite;

  // one strobe per writable register, all from the same bus access
  always_comb begin
    wrRamPos = wrEn && (offset == mmp_pkg::OFF_RAM_POS);
    wrRegPos = wrEn && (offset == mmp_pkg::OFF_REG_POS);
    wrEePos  = wrEn && (offset == mmp_pkg::OFF_EE_POS);
    wrMisc   = wrEn && (offset == mmp_pkg::OFF_MISC);
    wrPage   = wrEn && (offset == mmp_pkg::OFF_PAGE);
  end

  // special modes lift every write-once lock; a lock clears only on reset,
  // so a part that leaves special mode keeps whatever it wrote there
  always_comb begin
    ramMayWrite    = specialModeSync || !ramWritten;
    regMayWrite    = specialModeSync || !regWritten;
    eeBaseMayWrite = !EE_WRITE_ONCE || specialModeSync || !eeWritten;
    miscMayWrite   = specialModeSync || !miscWritten;
  end

  // ****************************************************************
  // mode and switch capture
  // ****************************************************************
  // mode pin comes from outside the clock domain
  always_ff @(posedge clk) begin
    if (rst) begin
      specialMode0    <= 1'b0;
      specialModeSync <= 1'b0;
    end else begin
      specialMode0    <= specialMode;
      specialModeSync <= specialMode0;
    end
  end

  // strap caught at the first clocked edge after reset, then held
  always_ff @(posedge clk) begin
    if (rst) begin
      sizeSwitchLoaded <= 1'b0;
      sizeSwitch       <= 1'b0;
    end else if (!sizeSwitchLoaded) begin
      sizeSwitchLoaded <= 1'b1;
      sizeSwitch       <= registerSpaceSizeSwitch;
    end
  end

  // ****************************************************************
  // ram position register
  // ****************************************************************
  // normal modes get a single write; special modes write freely
  always_ff @(posedge clk) begin
    if (rst) begin
      ramPosition <= mmp_pkg::RAM_POS_RST;
      ramWritten  <= 1'b0;
    end else if (wrRamPos && ramMayWrite) begin
      ramPosition <= pwdata[7:0] & mmp_pkg::RAM_POS_MASK;
      ramWritten  <= 1'b1;
    end
  end

  // ****************************************************************
  // register-space position register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      registerSpacePosition <= mmp_pkg::REG_POS_RST;
      regWritten            <= 1'b0;
    end else if (wrRegPos && regMayWrite) begin
      registerSpacePosition <= pwdata[7:0] & mmp_pkg::REG_POS_MASK;
      regWritten            <= 1'b1;
    end
  end

  // ****************************************************************
  // eeprom position register
  // ****************************************************************
  // enable bit always writable; base field rights set at integration
  // bits 2:1 are never written, so they keep their masked reset zeros
  always_ff @(posedge clk) begin
    if (rst) begin
      eepromPosition <= EE_POS_RESET & mmp_pkg::EE_POS_MASK;
      eeWritten      <= 1'b0;
    end else if (wrEePos) begin
      eepromPosition[mmp_pkg::EE_ENABLE_BIT] <= pwdata[mmp_pkg::EE_ENABLE_BIT];
      if (eeBaseMayWrite) begin
        eepromPosition[7:3] <= pwdata[7:3];
        eeWritten           <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // misc control and page index
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      miscSystemControl <= mmp_pkg::MISC_RST;
      miscWritten       <= 1'b0;
    end else if (wrMisc && miscMayWrite) begin
      miscSystemControl <= pwdata[7:0] & mmp_pkg::MISC_MASK;
      miscWritten       <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      programPageIndex <= mmp_pkg::PAGE_RST;
    end else if (wrPage) begin
      programPageIndex <= pwdata[7:0] & mmp_pkg::PAGE_MASK;
    end
  end

  // ****************************************************************
  // apb answer
  // ****************************************************************
  // zero-wait answer; unmapped offsets give pslverr and zero data
  // pready stands one cycle only, so every access phase lasts one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h00_0000, (mapped ? readByte : 8'h00)};
      end
    end
  end

  // ****************************************************************
  // decoder and live outputs
  // ****************************************************************
  mmp_decode_if decIf ();

  // settings go live from the register, so decode moves the next cycle
  assign decIf.ramBase      = ramPosition[7:3];
  assign decIf.ramHighAlign = ramPosition[mmp_pkg::RAM_ALIGN_BIT];
  assign decIf.regBase      = registerSpacePosition[6:3];
  assign decIf.regLarge     = sizeSwitch;
  assign decIf.eeBase       = eepromPosition[7:3];
  assign decIf.eeEnable     = eepromPosition[mmp_pkg::EE_ENABLE_BIT];

  // priority result, registered once inside the decoder
  mmp_pkg::mmp_sel_t sel;

  mmp_decoder u_decoder (
    .clk      (clk),
    .rst      (rst),
    .cfg      (decIf),
    .coreAddr (coreAddr),
    .sel      (sel)
  );

  // one-hot selects from the registered priority result
  always_ff @(posedge clk) begin
    if (rst) begin
      selRegs   <= 1'b0;
      selRam    <= 1'b0;
      selEeprom <= 1'b0;
    end else begin
      selRegs   <= (sel == mmp_pkg::SEL_REGS);
      selRam    <= (sel == mmp_pkg::SEL_RAM);
      selEeprom <= (sel == mmp_pkg::SEL_EEPROM);
    end
  end

  // misc and page settings out to the rest of the core
  // copies trail their register by one cycle, unlike the decode settings, which are wired straight from the registers
  always_ff @(posedge clk) begin
    if (rst) begin
      extStretch  <= mmp_pkg::MISC_RST[3:2];
      romHighOnly <= mmp_pkg::MISC_RST[1];
      romEnable   <= mmp_pkg::MISC_RST[0];
      pageIndex   <= mmp_pkg::PAGE_RST[5:0];
    end else begin
      extStretch  <= miscSystemControl[3:2];
      romHighOnly <= miscSystemControl[1];
      romEnable   <= miscSystemControl[0];
      pageIndex   <= programPageIndex[5:0];
    end
  end
endmodule
`default_nettype wire

// ==== bench/mmp_position_regs_properties.sv ====
// checker for the memory-map position register block ports
`timescale 1ns/10ps
`default_nettype none
module mmp_position_regs_properties #(
  parameter logic [7:0] EE_POS_RESET = 8'h00
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // decode and settings
  input wire logic [15:0] coreAddr,
  input wire logic        selRegs,
  input wire logic        selRam,
  input wire logic        selEeprom,
  input wire logic [5:0]  pageIndex
);
  // ********
  // helpers
  // ********
  logic [3:0] age;
  logic       eeprom_enable;
  logic       acc;
  assign acc = psel && penable && pready;
  // age keeps the decode check off until the strap and reset values settle
  always_ff @(posedge clk) begin
    if (rst) age <= 4'h0;
    else if (age != 4'hf) age <= age + 4'h1;
  end
  // shadow of the eeprom enable as written over the bus
  always_ff @(posedge clk) begin
    if (rst) eeprom_enable <= EE_POS_RESET[0];
    else if (acc && pwrite && paddr == 12'h048 && pstrb[0]) eeprom_enable <= pwdata[0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  setup_gives_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  one_select_a: assert property ($onehot0({selRegs, selRam, selEeprom}))
    else $error("several selects high");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  ee_off_a: assert property ((!eeprom_enable) [*3] |-> !selEeprom)
    else $error("eeprom selected while off");
  sel_steady_a: assert property ((age == 4'hf && $stable(coreAddr) && !acc) ##1
    ($stable(coreAddr) && !acc) [*3] |-> $stable({selRegs, selRam, selEeprom})) else $error("select moved");
  page_copy_a: assert property (acc && pwrite && paddr == 12'h0c0 |-> ##2 pageIndex == 6'($past(pwdata, 2)))
    else $error("page copy wrong");
  // main scenarios
  cov_write_c: cover property (acc && pwrite);
  cov_error_c: cover property (pslverr);
  cov_eeprom_c: cover property (selEeprom);
endmodule
bind mmp_position_regs mmp_position_regs_properties #(.EE_POS_RESET(EE_POS_RESET)) u_mmp_position_regs_properties (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .coreAddr, .selRegs, .selRam, .selEeprom, .pageIndex);
`default_nettype wire

// ==== bench/mmp_core_model.sv ====
// core-side model: drives the core address and samples the selects
`timescale 1ns/10ps
`default_nettype none
module mmp_core_model (
  // clock
  input  wire logic        clk,
  // address wanted by the bench
  input  wire logic [15:0] want,
  output logic [15:0]      coreAddr,
  // selects from the block
  input  wire logic        selRegs,
  input  wire logic        selRam,
  input  wire logic        selEeprom,
  output logic [2:0]       seen
);
  // address leaves on an edge; selects lag it, so the bench waits
  always_ff @(posedge clk) begin
    coreAddr <= want;
    seen     <= {selRegs, selRam, selEeprom};
  end
endmodule
`default_nettype wire

// ==== bench/test_memory_map_position_regs.sv ====
// self-checking bench for the memory-map position registers
`timescale 1ns/10ps
`default_nettype none
module test_memory_map_position_regs;
  localparam logic [7:0] EE_RST = 8'h71;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        specialMode = 1'b0;
  logic        sizeSw = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, rerr;
  logic [15:0] want = 16'h0000;
  logic [15:0] coreAddr;
  logic        selRegs, selRam, selEeprom, romHighOnly, romEnable;
  logic [1:0]  extStretch;
  logic [5:0]  pageIndex;
  logic [2:0]  seen;
  int          fails = 0;
  int          compares = 0;
  int          cyc = 0;
  // ********
  // harness
  // ********
  mmp_position_regs #(.EE_POS_RESET(EE_RST), .TEST0_VALUE(8'h3c), .TEST1_VALUE(8'hc3),
    .MEMSIZE0_LOW(8'h25), .MEMSIZE1_VALUE(8'h42)) u_mmp_position_regs (
    .clk, .rst, .specialMode, .registerSpaceSizeSwitch(sizeSw), .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .coreAddr, .selRegs, .selRam, .selEeprom,
    .extStretch, .romHighOnly, .romEnable, .pageIndex);
  mmp_core_model u_mmp_core_model (.clk, .want, .coreAddr, .selRegs, .selRam, .selEeprom, .seen);
  // 250 MHz clock
  always #2 clk = ~clk;
  // hang guard, well above the run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until ready is sampled high, the hang guard ends a stuck wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(rdat, {24'h0, x});
  endtask
  // selects need two cycles after the address, plus the model's own edges
  task automatic dec(input logic [15:0] a, input logic [2:0] x);
    want <= a;
    repeat (5) @(posedge clk);
    chk({29'h0, seen}, {29'h0, x});
  endtask
  task automatic do_reset(input logic sw, input logic sp);
    rst <= 1'b1;
    sizeSw <= sw;
    specialMode <= sp;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic t_reset;
    rd(12'h040, 8'h00);
    rd(12'h044, 8'h00);
    rd(12'h048, EE_RST);
    rd(12'h04c, 8'h0d);
    rd(12'h050, 8'h3c);
    rd(12'h05c, 8'hc3);
    rd(12'h070, 8'h25);
    rd(12'h074, 8'h42);
    rd(12'h0c4, 8'h00);
    chk({28'h0, extStretch, romHighOnly, romEnable}, 32'hd);
    dec(16'h0100, 3'h4);
    dec(16'h0500, 3'h2);
    dec(16'h7000, 3'h1);
    dec(16'h7800, 3'h0);
    $display("reset test done");
  endtask
  task automatic t_once;
    apb(1'b1, 12'h040, 8'hff);
    rd(12'h040, 8'hf9);
    apb(1'b1, 12'h040, 8'h40);
    rd(12'h040, 8'hf9);
    apb(1'b1, 12'h044, 8'hff);
    rd(12'h044, 8'h78);
    apb(1'b1, 12'h044, 8'h08);
    rd(12'h044, 8'h78);
    apb(1'b1, 12'h048, 8'hb1);
    apb(1'b1, 12'h048, 8'hb8);
    rd(12'h048, 8'hb8);
    apb(1'b1, 12'h0c0, 8'hff);
    rd(12'h0c0, 8'h3f);
    chk({26'h0, pageIndex}, 32'h3f);
    apb(1'b1, 12'h050, 8'h55);
    rd(12'h050, 8'h3c);
    apb(1'b0, 12'h060, 8'h00);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, 12'h041, 8'h00);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    apb(1'b1, 12'h04c, 8'hf6);
    rd(12'h04c, 8'h06);
    chk({28'h0, extStretch, romHighOnly, romEnable}, 32'h6);
    dec(16'h7bff, 3'h4);
    dec(16'h7c00, 3'h0);
    dec(16'hf900, 3'h2);
    dec(16'hb800, 3'h0);
    $display("normal mode test done");
  endtask
  task automatic t_special;
    rd(12'h070, 8'ha5);
    dec(16'h0700, 3'h4);
    apb(1'b1, 12'h040, 8'h40);
    apb(1'b1, 12'h040, 8'hb0);
    rd(12'h040, 8'hb0);
    apb(1'b1, 12'h048, 8'hb1);
    dec(16'hb000, 3'h2);
    apb(1'b1, 12'h040, 8'h48);
    dec(16'h4fff, 3'h2);
    dec(16'hb7ff, 3'h1);
    apb(1'b1, 12'h048, 8'hb0);
    dec(16'hb000, 3'h0);
    apb(1'b1, 12'h044, 8'h08);
    apb(1'b1, 12'h044, 8'h10);
    dec(16'h17ff, 3'h4);
    dec(16'h1800, 3'h0);
    apb(1'b1, 12'h040, 8'h49);
    dec(16'hf800, 3'h2);
    $display("special mode test done");
  endtask
  task automatic final_report;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence: normal mode with small register space, then special mode with large
  initial begin
    do_reset(1'b0, 1'b0);
    t_reset;
    t_once;
    do_reset(1'b1, 1'b1);
    t_special;
    final_report;
  end
endmodule
`default_nettype wire
